// file: hdl/cswm_ctrl.sv
// Purpose: CAN transceiver mode and wake status control across chip modes.
// Assumes: Host strobes are one-cycle pulses, synchronous to clock.
// Notes: Reactions to chip mode entries occur on the first cycle seen.
`timescale 1ns/1ps
`include "cswm_cfg.svh"
module cswm_ctrl
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Chip mode from the chip state machine
    input wire cswm_pkg::cswm_chip_t chip_mode,
    // Host control port
    input wire logic mode_wr_en,
    input wire logic [`CSWM_FIELD_W-1:0] mode_wr_data,
    input wire logic cfg_valid_set,
    input wire logic cfg_data_changed,
    input wire cswm_pkg::cswm_flags_t flag_clr,
    // Frame decoder events
    input wire cswm_pkg::cswm_bus_ev_t bus_ev,
    input wire logic [`CSWM_FRAME_ERROR_COUNT_W-1:0] frame_error_count_in,
    // Status to host and chip
    output logic [`CSWM_FIELD_W-1:0] can_mode_field,
    output cswm_pkg::cswm_xcvr_t xcvr_mode,
    output cswm_pkg::cswm_flags_t wake_flags,
    output logic [`CSWM_FRAME_ERROR_COUNT_W-1:0] frame_error_count,
    output logic wake_config_valid_bit,
    output logic restart_req,
    output logic wake_irq,
    output logic xcvr_armed
);
    import cswm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Field remap on sleep entry or restart from normal.

    // Codes 101-111 collapse to 101, 001-011 to 001; 000 and 100 are kept.
    function automatic logic [`CSWM_FIELD_W-1:0] remap
    (
        input logic [`CSWM_FIELD_W-1:0] f
    );
        logic [`CSWM_FIELD_W-1:0] r;
        r = f;
        if (f[1:0] != 2'h0)
            r = f[2] ? `CSWM_MODE_SEL : `CSWM_MODE_WAKE;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and combinational decode.

    cswm_chip_t prev_mode;
    cswm_arm_t arm_state;
    cswm_arm_t next_arm_state;
    cswm_xcvr_t map_mode;
    cswm_flags_t next_wake_flags;
    logic [`CSWM_FIELD_W-1:0] next_can_mode_field;
    logic [`CSWM_FRAME_ERROR_COUNT_W-1:0] next_frame_error_count;
    logic frame_error_count_hold;
    logic next_frame_error_count_hold;
    logic next_valid;
    logic next_restart_req;
    logic next_wake_irq;
    logic enter_sleep;
    logic in_sleep;
    logic restart_from_normal;
    logic restart_from_sleep;
    logic awake;
    logic host_wr;
    logic live;
    logic frame_wake;
    logic ovf_wake;
    logic pat_wake;
    logic run_frame;
    logic run_pat;
    logic can_event;
    logic err_set;
    logic err_clr_ok;

    cswm_mode_map u_map
    (
        .chip_mode(chip_mode),
        .field(can_mode_field),
        .config_error(wake_flags.wake_config_error_flag),
        .xcvr(map_mode)
    );

    assign xcvr_armed = (arm_state == arm_ready);

    always_comb
    begin
        enter_sleep = (chip_mode == chip_sleep) && (prev_mode != chip_sleep);
        in_sleep = (chip_mode == chip_sleep) && (prev_mode == chip_sleep);
        restart_from_normal = (chip_mode == chip_restart)
            && (prev_mode == chip_normal);
        restart_from_sleep = (chip_mode == chip_restart)
            && (prev_mode == chip_sleep);
        awake = (chip_mode == chip_normal) || (chip_mode == chip_stop);
        // Mode writes only count in normal mode
        host_wr = mode_wr_en && (chip_mode == chip_normal);
        // A woken transceiver ignores the bus until rearmed
        live = (arm_state == arm_ready) && (map_mode != xc_off);
        // Sleep wakes lead to restart
        frame_wake = in_sleep && live && (map_mode == xc_sel)
            && bus_ev.wake_frame;
        ovf_wake = in_sleep && live && (map_mode == xc_sel)
            && bus_ev.count_overflow;
        pat_wake = in_sleep && live && (map_mode == xc_wake)
            && bus_ev.wake_pattern;
        // Wakes while running raise an interrupt instead
        run_frame = awake && live && can_mode_field[2]
            && !wake_flags.wake_config_error_flag && bus_ev.wake_frame;
        run_pat = awake && live && (map_mode == xc_wake)
            && bus_ev.wake_pattern;
        can_event = frame_wake || ovf_wake || pat_wake || run_frame
            || run_pat;
        err_set = ovf_wake
            || (pat_wake && (can_mode_field == `CSWM_MODE_SEL))
            || (restart_from_normal && can_mode_field[2]
                && (can_mode_field[1:0] != 2'h0))
            // No CAN wake seen while armed: another source woke us.
            || (restart_from_sleep && (arm_state == arm_ready)
                && (can_mode_field == `CSWM_MODE_SEL));
        // Clear is refused while bit 2 is set without valid configuration
        err_clr_ok = !(can_mode_field[2] && !wake_config_valid_bit);
    end

    ////////////////////////////////////////////////////////////////////////
    // Arming state machine.

    always_comb
    begin
        next_arm_state = arm_state;
        unique case (arm_state)
            arm_ready:
            begin
                if (can_event)
                    next_arm_state = arm_woken;
            end
            arm_woken:
            begin
                if (enter_sleep)
                    next_arm_state = arm_ready;
                else if (host_wr && (mode_wr_data != can_mode_field))
                    next_arm_state = arm_changed;
            end
            arm_changed:
            begin
                if (enter_sleep)
                    next_arm_state = arm_ready;
                else if (host_wr && ((mode_wr_data == `CSWM_MODE_WAKE)
                    || (mode_wr_data == `CSWM_MODE_SEL)))
                    next_arm_state = arm_ready;
            end
            default:
            begin
                next_arm_state = arm_ready;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            arm_state <= arm_ready;
        else
            arm_state <= next_arm_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode field, flags, count and pulses.

    always_comb
    begin
        next_can_mode_field = can_mode_field;
        if (host_wr)
            next_can_mode_field = mode_wr_data;
        else if (enter_sleep)
            next_can_mode_field = remap(can_mode_field);
        else if (restart_from_normal)
            next_can_mode_field = remap(can_mode_field);

        // Set always wins over a host clear
        next_wake_flags.wake_config_error_flag = err_set
            || (wake_flags.wake_config_error_flag
                && !(flag_clr.wake_config_error_flag && err_clr_ok));
        next_wake_flags.can_wake_flag = can_event
            || (wake_flags.can_wake_flag && !flag_clr.can_wake_flag);
        // A frame inside bus silence leaves the pattern flag
        next_wake_flags.wake_pattern_flag = pat_wake || run_pat
            || ((frame_wake || run_frame) && !bus_ev.frame_in_silence)
            || (wake_flags.wake_pattern_flag && !flag_clr.wake_pattern_flag);
        next_wake_flags.wake_frame_flag = frame_wake || run_frame
            || (wake_flags.wake_frame_flag && !flag_clr.wake_frame_flag);

        // Hardware clear on a frame wake outranks the host set
        next_valid = wake_config_valid_bit;
        if (frame_wake || (cfg_data_changed && (chip_mode == chip_normal)))
            next_valid = 1'b0;
        else if (cfg_valid_set)
            next_valid = 1'b1;

        // Overflow value is held so the host can read it after restart.
        next_frame_error_count_hold = frame_error_count_hold && !flag_clr.can_wake_flag;
        next_frame_error_count = frame_error_count;
        if (ovf_wake)
        begin
            next_frame_error_count_hold = 1'b1;
            next_frame_error_count = `CSWM_FRAME_ERROR_COUNT_OVF;
        end
        else if (!frame_error_count_hold)
            next_frame_error_count = frame_error_count_in;

        next_restart_req = frame_wake || ovf_wake || pat_wake;
        next_wake_irq = run_frame || run_pat;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_mode <= chip_normal;
            can_mode_field <= `CSWM_MODE_OFF;
            xcvr_mode <= xc_off;
            wake_flags <= '0;
            frame_error_count <= `CSWM_FRAME_ERROR_COUNT_RST;
            frame_error_count_hold <= 1'b0;
            wake_config_valid_bit <= `CSWM_VALID_RST;
            restart_req <= 1'b0;
            wake_irq <= 1'b0;
        end
        else
        begin
            prev_mode <= chip_mode;
            can_mode_field <= next_can_mode_field;
            xcvr_mode <= map_mode;
            wake_flags <= next_wake_flags;
            frame_error_count <= next_frame_error_count;
            frame_error_count_hold <= next_frame_error_count_hold;
            wake_config_valid_bit <= next_valid;
            restart_req <= next_restart_req;
            wake_irq <= next_wake_irq;
        end
    end
endmodule

// file: hdl/cswm_mode_map.sv
// Purpose: Effective transceiver mode from chip mode, field and error flag.
// Assumes: Field holds the remapped value after sleep entry or restart from normal.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "cswm_cfg.svh"
module cswm_mode_map
(
    // Inputs
    input wire cswm_pkg::cswm_chip_t chip_mode,
    input wire logic [`CSWM_FIELD_W-1:0] field,
    input wire logic config_error,
    // Result
    output cswm_pkg::cswm_xcvr_t xcvr
);
    import cswm_pkg::*;

    always_comb
    begin
        xcvr = xc_off;
        unique case (chip_mode)
            chip_sleep:
            begin
                // Only three modes exist in sleep
                if (field[1:0] == 2'h0)
                    xcvr = xc_off;
                else if (field[2] && !config_error)
                    xcvr = xc_sel;
                else
                    xcvr = xc_wake;
            end
            chip_restart:
            begin
                if (field[1:0] == 2'h0)
                    xcvr = xc_off;
                else
                    xcvr = xc_wake;
            end
            chip_failsafe:
            begin
                xcvr = xc_wake;
            end
            default:
            begin
                // Normal and stop decode the programmed code
                unique case (field)
                    `CSWM_MODE_WAKE: xcvr = xc_wake;
                    `CSWM_MODE_RX: xcvr = xc_rx;
                    `CSWM_MODE_NORMAL:
                        xcvr = (chip_mode == chip_stop) ? xc_wake : xc_normal;
                    `CSWM_MODE_SEL:
                        xcvr = config_error ? xc_wake : xc_sel;
                    `CSWM_MODE_RX_SEL:
                        xcvr = config_error ? xc_rx : xc_rx_sel;
                    `CSWM_MODE_NORMAL_SEL:
                        xcvr = config_error ? xc_normal : xc_normal_sel;
                    default: xcvr = xc_off;
                endcase
            end
        endcase
    end
endmodule

// file: inc/cswm_cfg.svh
// Purpose: Constants for the CAN selective wake mode control block.
// Assumes: Mode field is three bits wide, error count six bits wide.
// Notes: Timing counts are not needed; all reactions are one cycle.
//
// Notes on behaviour
// - In sleep the transceiver is only off, wake capable or selective wake.
// - Sleep entry: 000 off, 001-011 become wake capable reading 001, 100 off.
// - Sleep entry with 101-111 reads 101; selective unless error flag set.
// - Wake frame in sleep restarts; valid bit cleared, error flag untouched.
// - After a CAN wake, rearm by writing another mode then the wake mode.
// - Every sleep entry rearms the transceiver automatically.
// - Restart from normal: 000/100 off, 001-011 to 001, 101-111 to 101 error.
// - Counter overflow wake sets error and CAN wake, count shows 100000.
// - Failed check drops selective wake, 101 runs wake capable; pattern wake sets error, wake, pattern.
// - Frame within bus silence leaves pattern flag clear, else sets it.
// - Other wake source: no CAN flags; with 101 the error flag is set.
// - Fail-safe entry forces wake capable mode without selective wake.
// - CAN wake restarts from sleep and interrupts in normal or stop.
// - Every CAN wake sets the CAN wake flag; an overflow wake sets no detail flag.
// - Field codes: 000/100 off, 001 wake, 010 rx, 011 normal, 101-111 selective.
// - Mode writes are ignored outside normal mode.
// - Error flag cannot clear while bit 2 is set and config is not valid.
`ifndef CSWM_CFG_SVH
`define CSWM_CFG_SVH

`define CSWM_FIELD_W 3
`define CSWM_FRAME_ERROR_COUNT_W 6

`define CSWM_MODE_OFF 3'h0
`define CSWM_MODE_WAKE 3'h1
`define CSWM_MODE_RX 3'h2
`define CSWM_MODE_NORMAL 3'h3
`define CSWM_MODE_OFF_SEL 3'h4
`define CSWM_MODE_SEL 3'h5
`define CSWM_MODE_RX_SEL 3'h6
`define CSWM_MODE_NORMAL_SEL 3'h7

`define CSWM_FRAME_ERROR_COUNT_OVF 6'h20
`define CSWM_FRAME_ERROR_COUNT_RST 6'h00
`define CSWM_VALID_RST 1'b0

`endif

// file: inc/cswm_pkg.sv
// Purpose: Types shared by the CAN selective wake mode control block.
// Assumes: Chip mode is decoded by the chip state machine outside.
// Notes: Chip mode codes follow a Gray walk normal, stop, restart, sleep.
package cswm_pkg;

    typedef enum logic [2:0]
    {
        chip_normal = 3'h0,
        chip_stop = 3'h1,
        chip_restart = 3'h3,
        chip_sleep = 3'h2,
        chip_failsafe = 3'h6
    } cswm_chip_t;

    typedef enum logic [2:0]
    {
        xc_off = 3'h0,
        xc_wake = 3'h1,
        xc_rx = 3'h2,
        xc_normal = 3'h3,
        xc_sel = 3'h5,
        xc_rx_sel = 3'h6,
        xc_normal_sel = 3'h7
    } cswm_xcvr_t;

    typedef enum logic [1:0]
    {
        arm_ready = 2'b00,
        arm_woken = 2'b01,
        arm_changed = 2'b11
    } cswm_arm_t;

    typedef struct packed
    {
        logic wake_config_error_flag;
        logic can_wake_flag;
        logic wake_pattern_flag;
        logic wake_frame_flag;
    } cswm_flags_t;

    typedef struct packed
    {
        logic wake_pattern;
        logic wake_frame;
        logic frame_in_silence;
        logic count_overflow;
    } cswm_bus_ev_t;

endpackage

// file: test/cswm_bus_model.sv
// Purpose: CAN bus side decoder stand-in producing wake events.
// Assumes: fire is a one-cycle request from the bench.
// Notes: Events are registered so they reach the block one edge later.
`timescale 1ns/1ps
`include "cswm_cfg.svh"
module cswm_bus_model
(
    // Clock and request
    input wire logic clock,
    input wire logic fire,
    input wire cswm_pkg::cswm_bus_ev_t kind,
    // Decoder outputs
    output cswm_pkg::cswm_bus_ev_t bus_ev = '0,
    output logic [`CSWM_FRAME_ERROR_COUNT_W-1:0] frame_error_count_in = 6'h03
);
    import cswm_pkg::*;
    // The count falls back at once so that the block must hold it itself.
    always @(posedge clock)
    begin
        bus_ev <= fire ? kind : '0;
        frame_error_count_in <= (fire && kind.count_overflow) ? 6'h20 : 6'h03;
    end
endmodule

// file: test/cswm_ctrl_monitor.sv
// Purpose: Port assertions for the CAN wake mode control block.
// Assumes: chip_mode rests at normal while rst_b is low.
// Notes: Bound to every cswm_ctrl instance at the foot of this file.
`timescale 1ns/1ps
`include "cswm_cfg.svh"
module cswm_ctrl_monitor
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Block inputs
    input wire cswm_pkg::cswm_chip_t chip_mode,
    input wire cswm_pkg::cswm_flags_t flag_clr,
    // Block outputs
    input wire logic [`CSWM_FIELD_W-1:0] can_mode_field,
    input wire cswm_pkg::cswm_xcvr_t xcvr_mode,
    input wire cswm_pkg::cswm_flags_t wake_flags,
    input wire logic wake_config_valid_bit,
    input wire logic restart_req,
    input wire logic wake_irq
);
    import cswm_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] slept(input logic [2:0] f);
        return (f[1:0] == 2'h0) ? f : (f[2] ? 3'h5 : 3'h1);
    endfunction
    sequence s_sleep_entry;
        chip_mode == chip_sleep && $past(chip_mode) == chip_normal;
    endsequence
    sequence s_settled_sleep;
        (chip_mode == chip_sleep) [*2];
    endsequence
    property p_sleep_map;
        s_sleep_entry |=> can_mode_field == slept($past(can_mode_field));
    endproperty
    property p_sleep_modes;
        s_settled_sleep |=> xcvr_mode inside {xc_off, xc_wake, xc_sel};
    endproperty
    property p_restart_map;
        chip_mode == chip_restart && $past(chip_mode) == chip_normal
            && can_mode_field[2] && can_mode_field[1:0] != 2'h0
            |=> can_mode_field == 3'h5 && wake_flags.wake_config_error_flag;
    endproperty
    property p_failsafe;
        (chip_mode == chip_failsafe) [*2] |=> xcvr_mode == xc_wake;
    endproperty
    property p_stop_hold;
        chip_mode == chip_stop |=> $stable(can_mode_field);
    endproperty
    property p_wake_flag;
        restart_req || wake_irq |-> wake_flags.can_wake_flag;
    endproperty
    property p_restart_sleep;
        restart_req |-> $past(chip_mode) == chip_sleep && !wake_irq;
    endproperty
    property p_irq_awake;
        wake_irq |-> $past(chip_mode) inside {chip_normal, chip_stop};
    endproperty
    property p_frame_wake;
        restart_req && $rose(wake_flags.wake_frame_flag)
            |-> !wake_config_valid_bit && can_mode_field == 3'h5;
    endproperty
    property p_err_hold;
        flag_clr.wake_config_error_flag && wake_flags.wake_config_error_flag
            && can_mode_field[2] && !wake_config_valid_bit
            |=> wake_flags.wake_config_error_flag;
    endproperty
    property p_sticky;
        (~wake_flags & $past(wake_flags) & ~$past(flag_clr)) == 4'h0;
    endproperty
    a_sleep_map: assert property (p_sleep_map)
        else $error("sleep entry field remap wrong");
    a_sleep_modes: assert property (p_sleep_modes)
        else $error("illegal transceiver mode in sleep");
    a_restart_map: assert property (p_restart_map)
        else $error("restart from normal remap wrong");
    a_failsafe: assert property (p_failsafe)
        else $error("fail-safe not wake capable");
    a_stop_hold: assert property (p_stop_hold)
        else $error("mode field changed in stop");
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake without CAN wake flag");
    a_restart_sleep: assert property (p_restart_sleep)
        else $error("restart request outside sleep");
    a_irq_awake: assert property (p_irq_awake)
        else $error("wake interrupt outside normal or stop");
    a_frame_wake: assert property (p_frame_wake)
        else $error("frame wake left valid bit or field wrong");
    a_err_hold: assert property (p_err_hold)
        else $error("error flag cleared without valid config");
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without host clear");
endmodule

bind cswm_ctrl cswm_ctrl_monitor u_monitor (.clock, .rst_b, .chip_mode,
    .flag_clr, .can_mode_field, .xcvr_mode, .wake_flags,
    .wake_config_valid_bit, .restart_req, .wake_irq);

// file: test/tb_can_selective_wake_mode_ctrl.sv
// Purpose: Self-checking bench for the CAN wake mode control block.
// Assumes: Inputs change on the falling clock edge.
// Notes: One task per scenario.
`timescale 1ns/1ps
`include "cswm_cfg.svh"
module tb_can_selective_wake_mode_ctrl;
    import cswm_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    cswm_chip_t chip_mode = chip_normal;
    logic mode_wr_en = 1'b0;
    logic [2:0] mode_wr_data = 3'h0;
    logic cfg_valid_set = 1'b0;
    logic cfg_data_changed = 1'b0;
    logic fire = 1'b0;
    cswm_flags_t flag_clr = '0;
    cswm_bus_ev_t kind = '0;
    cswm_bus_ev_t bus_ev;
    logic [5:0] frame_error_count_in, frame_error_count;
    logic [2:0] can_mode_field;
    cswm_xcvr_t xcvr_mode;
    cswm_flags_t wake_flags;
    logic wake_config_valid_bit, restart_req, wake_irq, xcvr_armed;
    int num_errors = 0;
    int tests_run = 0;
    int n_restart = 0;
    int n_irq = 0;

    always #2.5 clock = ~clock;
    always @(posedge clock)
    begin
        if (restart_req === 1'b1)
            n_restart++;
        if (wake_irq === 1'b1)
            n_irq++;
    end

    cswm_ctrl DUT (.clock, .rst_b, .chip_mode, .mode_wr_en, .mode_wr_data,
        .cfg_valid_set, .cfg_data_changed, .flag_clr, .bus_ev,
        .frame_error_count_in, .can_mode_field, .xcvr_mode, .wake_flags,
        .frame_error_count, .wake_config_valid_bit, .restart_req, .wake_irq,
        .xcvr_armed);
    cswm_bus_model u_bus (.clock, .fire, .kind, .bus_ev,
        .frame_error_count_in);
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [2:0] m);
        mode_wr_en = 1'b1;
        mode_wr_data = m;
        tick(1);
        mode_wr_en = 1'b0;
        tick(1);
    endtask
    task automatic go(input cswm_chip_t c);
        chip_mode = c;
        tick(3);
    endtask
    task automatic fire_ev(input cswm_bus_ev_t k);
        kind = k;
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(4);
    endtask
    // Host arming order, always done while the chip is in normal.
    task automatic prep(input logic [2:0] code);
        wr(3'h1);
        cfg_valid_set = 1'b1;
        tick(1);
        cfg_valid_set = 1'b0;
        flag_clr = '1;
        tick(1);
        flag_clr = '0;
        wr(code);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic sleep_table();
        logic [2:0] ef;
        cswm_xcvr_t ex;
        cswm_xcvr_t er;
        for (int c = 0; c < 8; c++)
        begin
            ef = c[2] ? 3'h5 : 3'h1;
            ex = c[2] ? xc_sel : xc_wake;
            er = xc_wake;
            if (c[1:0] == 2'h0)
            begin
                ef = c[2:0];
                ex = xc_off;
                er = xc_off;
            end
            prep(c[2:0]);
            go(chip_sleep);
            check("sleep field", can_mode_field, ef);
            check("sleep xcvr", xcvr_mode, ex);
            go(chip_restart);
            check("other", wake_flags, {ex == xc_sel, 3'h0});
            check("restart xcvr", xcvr_mode, er);
            go(chip_normal);
        end
    endtask
    task automatic wake_case(input logic [2:0] code, input cswm_bus_ev_t ev,
        input cswm_flags_t exp, input logic [3:0] mask);
        int r;
        r = n_restart;
        prep(code);
        go(chip_sleep);
        fire_ev(ev);
        check("wake flags", wake_flags & mask, exp);
        check("restart count", 8'(n_restart - r), 8'h01);
        check("wake field", can_mode_field, {code[2], 2'h1});
        if (ev.wake_frame)
            check("valid bit", wake_config_valid_bit, 1'b0);
        check("armed after wake", xcvr_armed, 1'b0);
        go(chip_restart);
        go(chip_normal);
    endtask
    task automatic rearm_case();
        int q;
        q = n_irq;
        prep(3'h1);
        fire_ev(4'b1000);
        check("irq count", 8'(n_irq - q), 8'h01);
        check("woken", xcvr_armed, 1'b0);
        wr(3'h0);
        check("other mode", xcvr_armed, 1'b0);
        wr(3'h1);
        check("rearmed", xcvr_armed, 1'b1);
        fire_ev(4'b1000);
        go(chip_sleep);
        check("sleep rearm", xcvr_armed, 1'b1);
        go(chip_restart);
        go(chip_normal);
    endtask
    task automatic fail_case();
        prep(3'h4);
        go(chip_restart);
        check("restart off", wake_flags, 4'h0);
        check("restart off xcvr", xcvr_mode, xc_off);
        go(chip_normal);
        prep(3'h6);
        go(chip_restart);
        check("restart field", can_mode_field, 3'h5);
        check("restart error", wake_flags, 4'b1000);
        go(chip_normal);
        cfg_data_changed = 1'b1;
        tick(1);
        cfg_data_changed = 1'b0;
        flag_clr = '1;
        tick(1);
        flag_clr = '0;
        tick(1);
        check("held error", wake_flags, 4'b1000);
        go(chip_sleep);
        check("fallback xcvr", xcvr_mode, xc_wake);
        fire_ev(4'b1000);
        check("fallback flags", wake_flags, 4'b1110);
        check("fallback field", can_mode_field, 3'h5);
        go(chip_restart);
        go(chip_normal);
    endtask
    task automatic stop_fail_case();
        int q;
        q = n_irq;
        prep(3'h5);
        chip_mode = chip_stop;
        wr(3'h3);
        check("stop field", can_mode_field, 3'h5);
        // A frame wake while in stop must raise the interrupt, not restart.
        fire_ev(4'b0100);
        check("stop irq", 8'(n_irq - q), 8'h01);
        check("stop flags", wake_flags, 4'b0111);
        go(chip_failsafe);
        check("failsafe xcvr", xcvr_mode, xc_wake);
        go(chip_normal);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(2);
        rst_b = 1'b1;
        tick(1);
        sleep_table();
        wake_case(3'h7, 4'b0110, 4'b0101, 4'hf);
        wake_case(3'h6, 4'b0100, 4'b0111, 4'hf);
        wake_case(3'h2, 4'b1000, 4'b0110, 4'hf);
        wake_case(3'h5, 4'b0001, 4'b1100, 4'hd);
        check("error count", frame_error_count, 6'h20);
        rearm_case();
        fail_case();
        stop_fail_case();
        complete_run();
    end
    initial
    begin
        #20000;
        num_errors++;
        complete_run();
    end
endmodule
